// ===== logic/bst_pkg.sv
package bst_pkg;

	////////////////////////////////////////////////////////////////////////
	// instruction register
	localparam int         IR_W       = 3;
	localparam logic [2:0] IR_EXTEST  = 3'h0;
	localparam logic [2:0] IR_IDCODE  = 3'h1;
	localparam logic [2:0] IR_SAMPLE  = 3'h2;
	localparam logic [2:0] IR_CLAMP   = 3'h3;
	localparam logic [2:0] IR_HIGHZ   = 3'h4;
	localparam logic [2:0] IR_BYPASS  = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam logic [2:0] IR_RESET   = IR_IDCODE;

	////////////////////////////////////////////////////////////////////////
	// identification word layout
	localparam int ID_W     = 32;
	localparam int ID_REV_W = 4;
	localparam int ID_DEV_W = 16;
	localparam int ID_MFR_W = 11;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser: bit0 clock, bit1 mode select, bit2 data, bit3 reset
	localparam int         PIN_W       = 4;
	localparam int         PIN_TCK     = 0;
	localparam int         PIN_TMS     = 1;
	localparam int         PIN_TDI     = 2;
	localparam int         PIN_TRST    = 3;
	localparam logic [3:0] PIN_RST_VAL = 4'h2;
	localparam logic [2:0] TMS_RUN_LEN = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// controller states and pad modes
	typedef enum logic [15:0] {
		ST_RESET  = 16'h0001,
		ST_IDLE   = 16'h0002,
		ST_SELDR  = 16'h0004,
		ST_CAPDR  = 16'h0008,
		ST_SHDR   = 16'h0010,
		ST_EX1DR  = 16'h0020,
		ST_PAUSDR = 16'h0040,
		ST_EX2DR  = 16'h0080,
		ST_UPDDR  = 16'h0100,
		ST_SELIR  = 16'h0200,
		ST_CAPIR  = 16'h0400,
		ST_SHIR   = 16'h0800,
		ST_EX1IR  = 16'h1000,
		ST_PAUSIR = 16'h2000,
		ST_EX2IR  = 16'h4000,
		ST_UPDIR  = 16'h8000
	} bst_state_t;

	typedef enum logic [2:0] {
		PAD_NORMAL = 3'h1,
		PAD_BSR    = 3'h2,
		PAD_HIZ    = 3'h4
	} bst_pad_mode_t;

endpackage

// ===== logic/bst_sync.sv
`timescale 1ns/10ps

module bst_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// first stage feeds the second stage only
	logic [W-1:0] meta_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule // bst_sync

// ===== logic/bst_bsr.sv
`timescale 1ns/10ps

module bst_bsr #(
	parameter int             W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// scan controls, one-cycle pulses
	input  wire logic         captureEn,
	input  wire logic         shiftEn,
	input  wire logic         updateEn,
	// data
	input  wire logic [W-1:0] captureData,
	input  wire logic         serialIn,
	output logic              serialOut,
	output logic      [W-1:0] parallelOut
);

	logic [W-1:0] shift_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			shift_q <= '0;
		else if (captureEn)
			shift_q <= captureData;
		else if (shiftEn)
			shift_q <= {serialIn, shift_q[W-1:1]};
	end

	// update latch keeps pads steady while the chain moves
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			parallelOut <= '0;
		else if (updateEn)
			parallelOut <= shift_q;
	end

	assign serialOut = shift_q[0];

endmodule // bst_bsr

// ===== logic/bst_tap.sv
`timescale 1ns/10ps

// Functional notes
// - state moves only on test clock rising edges, steered by mode select, or to reset while reset pin is low
// - reset pin low forces reset state and IDCODE; pads stay normal
// - five rising edges with mode select high reach the reset state
// - select-DR holds registers; low goes capture-DR, high select-IR
// - capture-DR loads the selected register; then shift-DR or exit1-DR
// - shift-DR shifts selected register toward data out; others hold
// - exit1-DR goes update-DR on high, pause-DR on low
// - pause-DR holds on low; exit2-DR goes update-DR or shift-DR
// - update-DR falling edge latches chain; next idle or select-DR
// - select-IR holds all; low capture-IR, high back to reset state
// - capture-IR loads 001, then exit1-IR on high or shift-IR on low
// - shift-IR shifts instruction bits per edge; others hold
// - exit1-IR, pause-IR and exit2-IR follow mode select as listed
// - update-IR falling edge makes shifted instruction current
// - three-bit instruction decode; unused codes select bypass
// - sample/preload captures pins and preloads without touching pads
// - extest captures inputs and drives pads from updated chain
// - sample, idcode, bypass and unused codes return pads to normal at update-IR rise
// - bypass puts a single one-bit stage between data pins
// - IDCODE selects 32-bit id word, captured then shifted, bit0 one
// - highz floats every output from update-IR rise, bypass selected
// - clamp drives pads from chain latches with bypass selected
module bst_tap #(
	parameter int                    N_IN   = 8,
	parameter int                    N_OUT  = 8,
	// arbitrary neutral identification values
	parameter logic [3:0]            ID_REV = 4'h0,
	parameter logic [15:0]           ID_DEV = 16'h0001,
	parameter logic [10:0]           ID_MFR = 11'h001
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// test access pins
	input  wire logic                testClockPin,
	input  wire logic                testModeSelectPin,
	input  wire logic                testDataInPin,
	input  wire logic                testResetPin_n,
	output logic                     testDataOutPin,
	output logic                     testDataOutEn,
	// core side
	input  wire logic [N_OUT-1:0]    sysOut,
	input  wire logic [N_OUT-1:0]    sysOutEn,
	output logic      [N_IN-1:0]     coreIn,
	// pads
	input  wire logic [N_IN-1:0]     padIn,
	output logic      [N_OUT-1:0]    padOut,
	output logic      [N_OUT-1:0]    padOutEn
);

	localparam int BSR_W = N_IN + N_OUT;

	////////////////////////////////////////////////////////////////////////
	// pin sampling and clock edge detection

	logic [bst_pkg::PIN_W-1:0] pinS;
	logic                      tckS;
	logic                      tmsS;
	logic                      tdiS;
	logic                      trstS_n;
	logic                      tckPrev_q;
	logic                      riseEv;
	logic                      fallEv;

	bst_sync #(
		.W       (bst_pkg::PIN_W),
		.RST_VAL (bst_pkg::PIN_RST_VAL)
	) u_pinSync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({testResetPin_n, testDataInPin,
		         testModeSelectPin, testClockPin}),
		.q     (pinS)
	);

	// pad inputs reach the core through the same two stages
	bst_sync #(
		.W       (N_IN),
		.RST_VAL ('0)
	) u_padSync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (padIn),
		.q     (coreIn)
	);

	assign tckS    = pinS[bst_pkg::PIN_TCK];
	assign tmsS    = pinS[bst_pkg::PIN_TMS];
	assign tdiS    = pinS[bst_pkg::PIN_TDI];
	assign trstS_n = pinS[bst_pkg::PIN_TRST];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tckPrev_q <= 1'b0;
		else
			tckPrev_q <= tckS;
	end

	assign riseEv = tckS & ~tckPrev_q;
	assign fallEv = ~tckS & tckPrev_q;

	////////////////////////////////////////////////////////////////////////
	// controller

	bst_pkg::bst_state_t state_q;
	bst_pkg::bst_state_t state_d;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			bst_pkg::ST_RESET:  state_d = tmsS ? bst_pkg::ST_RESET
			                                   : bst_pkg::ST_IDLE;
			bst_pkg::ST_IDLE:   state_d = tmsS ? bst_pkg::ST_SELDR
			                                   : bst_pkg::ST_IDLE;
			bst_pkg::ST_SELDR:  state_d = tmsS ? bst_pkg::ST_SELIR
			                                   : bst_pkg::ST_CAPDR;
			bst_pkg::ST_CAPDR:  state_d = tmsS ? bst_pkg::ST_EX1DR
			                                   : bst_pkg::ST_SHDR;
			bst_pkg::ST_SHDR:   state_d = tmsS ? bst_pkg::ST_EX1DR
			                                   : bst_pkg::ST_SHDR;
			bst_pkg::ST_EX1DR:  state_d = tmsS ? bst_pkg::ST_UPDDR
			                                   : bst_pkg::ST_PAUSDR;
			bst_pkg::ST_PAUSDR: state_d = tmsS ? bst_pkg::ST_EX2DR
			                                   : bst_pkg::ST_PAUSDR;
			bst_pkg::ST_EX2DR:  state_d = tmsS ? bst_pkg::ST_UPDDR
			                                   : bst_pkg::ST_SHDR;
			bst_pkg::ST_UPDDR:  state_d = tmsS ? bst_pkg::ST_SELDR
			                                   : bst_pkg::ST_IDLE;
			bst_pkg::ST_SELIR:  state_d = tmsS ? bst_pkg::ST_RESET
			                                   : bst_pkg::ST_CAPIR;
			bst_pkg::ST_CAPIR:  state_d = tmsS ? bst_pkg::ST_EX1IR
			                                   : bst_pkg::ST_SHIR;
			bst_pkg::ST_SHIR:   state_d = tmsS ? bst_pkg::ST_EX1IR
			                                   : bst_pkg::ST_SHIR;
			bst_pkg::ST_EX1IR:  state_d = tmsS ? bst_pkg::ST_UPDIR
			                                   : bst_pkg::ST_PAUSIR;
			bst_pkg::ST_PAUSIR: state_d = tmsS ? bst_pkg::ST_EX2IR
			                                   : bst_pkg::ST_PAUSIR;
			bst_pkg::ST_EX2IR:  state_d = tmsS ? bst_pkg::ST_UPDIR
			                                   : bst_pkg::ST_SHIR;
			bst_pkg::ST_UPDIR:  state_d = tmsS ? bst_pkg::ST_SELDR
			                                   : bst_pkg::ST_IDLE;
			default:            state_d = bst_pkg::ST_RESET;
		endcase
	end

	// the sampled reset pin wins over any clock edge
	always_ff @(posedge clk)
	begin
		if (!rst_n || !trstS_n)
			state_q <= bst_pkg::ST_RESET;
		else if (riseEv)
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////////
	// instruction register

	logic [bst_pkg::IR_W-1:0] irShift_q;
	logic [bst_pkg::IR_W-1:0] ir_q;
	logic                     selBsr;
	logic                     selId;
	logic                     selByp;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			irShift_q <= bst_pkg::IR_CAPTURE;
		else if (riseEv && state_q == bst_pkg::ST_CAPIR)
			irShift_q <= bst_pkg::IR_CAPTURE;
		else if (riseEv && state_q == bst_pkg::ST_SHIR)
			irShift_q <= {tdiS, irShift_q[bst_pkg::IR_W-1:1]};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || state_q == bst_pkg::ST_RESET)
			ir_q <= bst_pkg::IR_RESET;
		else if (fallEv && state_q == bst_pkg::ST_UPDIR)
			ir_q <= irShift_q;
	end

	// codes 5 and 6 fall through to bypass
	assign selBsr = (ir_q == bst_pkg::IR_EXTEST)
	             || (ir_q == bst_pkg::IR_SAMPLE);
	assign selId  = (ir_q == bst_pkg::IR_IDCODE);
	assign selByp = !selBsr && !selId;

	////////////////////////////////////////////////////////////////////////
	// data registers

	logic                  capDr;
	logic                  shDr;
	logic                  bypass_q;
	logic [bst_pkg::ID_W-1:0] idShift_q;
	logic                  bsrSerial;
	logic [BSR_W-1:0]      bsrPar;

	assign capDr = riseEv && state_q == bst_pkg::ST_CAPDR;
	assign shDr  = riseEv && state_q == bst_pkg::ST_SHDR;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bypass_q <= 1'b0;
		else if (capDr && selByp)
			bypass_q <= 1'b0;
		else if (shDr && selByp)
			bypass_q <= tdiS;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			idShift_q <= '0;
		else if (capDr && selId)
			idShift_q <= {ID_REV, ID_DEV, ID_MFR, 1'b1};
		else if (shDr && selId)
			idShift_q <= {tdiS, idShift_q[bst_pkg::ID_W-1:1]};
	end

	// input cells low, output cells high; shifting never touches pads
	bst_bsr #(
		.W (BSR_W)
	) u_bsr (
		.clk         (clk),
		.rst_n       (rst_n),
		.captureEn   (capDr && selBsr),
		.shiftEn     (shDr && selBsr),
		.updateEn    (fallEv && state_q == bst_pkg::ST_UPDDR
		              && selBsr),
		.captureData ({sysOut, coreIn}),
		.serialIn    (tdiS),
		.serialOut   (bsrSerial),
		.parallelOut (bsrPar)
	);

	////////////////////////////////////////////////////////////////////////
	// serial output, changes on the falling test clock edge

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			testDataOutPin <= 1'b0;
			testDataOutEn  <= 1'b0;
		end
		else if (fallEv)
		begin
			testDataOutEn <= state_q == bst_pkg::ST_SHDR
			              || state_q == bst_pkg::ST_SHIR;
			if (state_q == bst_pkg::ST_SHIR)
				testDataOutPin <= irShift_q[0];
			else if (selBsr)
				testDataOutPin <= bsrSerial;
			else if (selId)
				testDataOutPin <= idShift_q[0];
			else
				testDataOutPin <= bypass_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pad control

	bst_pkg::bst_pad_mode_t padMode_q;

	// mode switches on the rising edge that leaves update-IR;
	// the reset state always hands the pads back to the core
	always_ff @(posedge clk)
	begin
		if (!rst_n || !trstS_n || state_q == bst_pkg::ST_RESET)
			padMode_q <= bst_pkg::PAD_NORMAL;
		else if (riseEv && state_q == bst_pkg::ST_UPDIR)
		begin
			if (ir_q == bst_pkg::IR_EXTEST || ir_q == bst_pkg::IR_CLAMP)
				padMode_q <= bst_pkg::PAD_BSR;
			else if (ir_q == bst_pkg::IR_HIGHZ)
				padMode_q <= bst_pkg::PAD_HIZ;
			else
				padMode_q <= bst_pkg::PAD_NORMAL;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			padOut   <= '0;
			padOutEn <= '0;
		end
		else
		begin
			unique case (padMode_q)
				bst_pkg::PAD_BSR:
				begin
					padOut   <= bsrPar[N_IN +: N_OUT];
					padOutEn <= '1;
				end
				bst_pkg::PAD_HIZ:
				begin
					padOut   <= sysOut;
					padOutEn <= '0;
				end
				default:
				begin
					padOut   <= sysOut;
					padOutEn <= sysOutEn;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	// count of consecutive rising edges with mode select high
	logic [2:0] tmsRun_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tmsRun_q <= 3'h0;
		else if (riseEv)
			tmsRun_q <= !tmsS ? 3'h0 :
			            (tmsRun_q == bst_pkg::TMS_RUN_LEN) ? tmsRun_q
			                                               : tmsRun_q + 3'h1;
	end

	a_five_tms: assert property (
		@(posedge clk) disable iff (!rst_n)
		tmsRun_q == bst_pkg::TMS_RUN_LEN |-> state_q == bst_pkg::ST_RESET)
		else $error("five high mode select edges did not reach reset");

	a_trst_idcode: assert property (
		@(posedge clk) disable iff (!rst_n)
		!trstS_n |=> state_q == bst_pkg::ST_RESET ##1
		ir_q == bst_pkg::IR_IDCODE)
		else $error("reset pin did not force reset state and idcode");

	a_no_move: assert property (
		@(posedge clk) disable iff (!rst_n)
		!riseEv && trstS_n |=> $stable(state_q))
		else $error("state changed without a test clock rise");

	a_capir_load: assert property (
		@(posedge clk) disable iff (!rst_n)
		riseEv && state_q == bst_pkg::ST_CAPIR |=> irShift_q == 3'h1)
		else $error("capture-IR did not load the fixed pattern");

	a_seldr_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		state_q == bst_pkg::ST_SELDR |=> $stable(irShift_q)
		&& $stable(bypass_q) && $stable(idShift_q))
		else $error("registers changed in select-DR");

	a_bypass_shift: assert property (
		@(posedge clk) disable iff (!rst_n)
		shDr && selByp |=> bypass_q == $past(tdiS))
		else $error("bypass stage did not take the data input");

	a_exit1_next: assert property (
		@(posedge clk) disable iff (!rst_n)
		riseEv && trstS_n && state_q == bst_pkg::ST_EX1DR |=>
		state_q == ($past(tmsS) ? bst_pkg::ST_UPDDR : bst_pkg::ST_PAUSDR))
		else $error("exit1-DR went to the wrong state");

	a_ir_update: assert property (
		@(posedge clk) disable iff (!rst_n)
		fallEv && state_q == bst_pkg::ST_UPDIR |=> ir_q == $past(irShift_q))
		else $error("instruction not latched in update-IR");

	a_highz_float: assert property (
		@(posedge clk) disable iff (!rst_n)
		riseEv && trstS_n && state_q == bst_pkg::ST_UPDIR
		&& ir_q == bst_pkg::IR_HIGHZ ##1 trstS_n |=> padOutEn == '0)
		else $error("highz did not float the outputs");

	a_id_capture: assert property (
		@(posedge clk) disable iff (!rst_n)
		capDr && selId |=> idShift_q[0] == 1'b1)
		else $error("identification word bit 0 not one");

endmodule // bst_tap

// ===== verification/bst_tester.sv
`timescale 1ns/10ps

module bst_tester (
	// test access pins
	output logic      testClockPin,
	output logic      testModeSelectPin,
	output logic      testDataInPin,
	output logic      testResetPin_n,
	input  wire logic testDataOutPin
);

	// test clock stands still low between frames
	initial
	begin
		testClockPin      = 1'b0;
		testModeSelectPin = 1'b1;
		testDataInPin     = 1'b0;
		testResetPin_n    = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// one 80 ns test clock period; data out is read late in the low phase
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		testModeSelectPin = tms;
		testDataInPin     = tdi;
		#20 testClockPin  = 1'b1;
		#40 testClockPin  = 1'b0;
		// data in is not held after the edge: flip it, no stale level
		testDataInPin     = ~tdi;
		#20 tdo           = testDataOutPin;
	endtask

	task automatic reset_pulse();
		testResetPin_n    = 1'b0;
		#40 testResetPin_n = 1'b1;
		#20;
	endtask

	// reset without the reset pin, from whatever state
	task automatic tms_reset();
		logic tdo;
		repeat (5) tick(1'b1, 1'b0, tdo);
	endtask

endmodule // bst_tester

// ===== verification/testbench.sv
`timescale 1ns/10ps

module testbench;

	// arbitrary identification values
	localparam logic [3:0]  ID_REV  = 4'ha;
	localparam logic [15:0] ID_DEV  = 16'h1234;
	localparam logic [10:0] ID_MFR  = 11'h2a5;
	localparam logic [31:0] ID_EXP  = {ID_REV, ID_DEV, ID_MFR, 1'b1};
	localparam int          LIMIT   = 40000;

	logic       clk;
	logic       rst_n;
	logic       testClockPin;
	logic       testModeSelectPin;
	logic       testDataInPin;
	logic       testResetPin_n;
	logic       testDataOutPin;
	logic       testDataOutEn;
	logic [7:0] sysOut;
	logic [7:0] sysOutEn;
	logic [7:0] coreIn;
	logic [7:0] padIn;
	logic [7:0] padOut;
	logic [7:0] padOutEn;
	logic       tdo;
	int         mismatches;
	int         samplesChecked;
	int         cycles;

	initial clk = 1'b0;
	always #2 clk = ~clk;

	bst_tap #(.N_IN(8), .N_OUT(8), .ID_REV(ID_REV), .ID_DEV(ID_DEV),
		.ID_MFR(ID_MFR)) bst_tap_inst (
		.clk(clk), .rst_n(rst_n), .testClockPin(testClockPin),
		.testModeSelectPin(testModeSelectPin),
		.testDataInPin(testDataInPin), .testResetPin_n(testResetPin_n),
		.testDataOutPin(testDataOutPin), .testDataOutEn(testDataOutEn),
		.sysOut(sysOut), .sysOutEn(sysOutEn), .coreIn(coreIn),
		.padIn(padIn), .padOut(padOut), .padOutEn(padOutEn));

	bst_tester bst_tester_inst (
		.testClockPin(testClockPin), .testModeSelectPin(testModeSelectPin),
		.testDataInPin(testDataInPin), .testResetPin_n(testResetPin_n),
		.testDataOutPin(testDataOutPin));

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tk(input logic tms);
		bst_tester_inst.tick(tms, 1'b0, tdo);
	endtask

	// from reset or idle through one scan and back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		input int pauseAt, output logic [31:0] dout);
		logic enOk;
		dout = '0;
		enOk = 1'b1;
		tk(1'b0);
		tk(1'b1);
		if (ir)
			tk(1'b1);
		tk(1'b0);
		tk(1'b0);
		for (int i = 0; i < n; i++)
		begin
			dout[i] = tdo;
			enOk = enOk & (testDataOutEn === 1'b1);
			bst_tester_inst.tick(i == n - 1 || i == pauseAt, din[i], tdo);
			if (i == pauseAt && i != n - 1)
			begin
				tk(1'b0);
				tk(1'b0);
				tk(1'b1);
				tk(1'b0);
			end
		end
		check(32'(testDataOutEn), 32'h0);
		check(32'(enOk), 32'h1);
		tk(1'b1);
		tk(1'b0);
	endtask

	task automatic load_ir(input logic [2:0] code);
		logic [31:0] dout;
		scan(1'b1, 3, {29'h0, code}, code[0] ? 1 : 99, dout);
		check(dout, 32'h1);
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic test_reset_id();
		logic [31:0] dout;
		bst_tester_inst.reset_pulse();
		check(32'({padOut, padOutEn}), 32'({sysOut, sysOutEn}));
		scan(1'b0, 32, 32'h0, 10, dout);
		check(dout, ID_EXP);
		$display("test reset_id done");
	endtask

	task automatic test_sample_extest();
		logic [31:0] dout;
		padIn = 8'h5c;
		settle();
		load_ir(bst_pkg::IR_SAMPLE);
		check(32'({padOut, padOutEn}), 32'({sysOut, sysOutEn}));
		scan(1'b0, 16, 32'h3c96, 99, dout);
		check(dout, 32'ha35c);
		check(32'({padOut, coreIn}), 32'({sysOut, padIn}));
		load_ir(bst_pkg::IR_EXTEST);
		check(32'({padOut, padOutEn}), 32'h3cff);
		padIn = 8'h17;
		settle();
		scan(1'b0, 16, 32'hc300, 99, dout);
		check(dout, 32'ha317);
		check(32'(padOut), 32'hc3);
		$display("test sample_extest done");
	endtask

	task automatic test_bypass_codes();
		logic [2:0]  codes [5];
		logic [31:0] dout;
		codes = '{3'h4, 3'h3, 3'h5, 3'h6, 3'h7};
		foreach (codes[k])
		begin
			load_ir(codes[k]);
			scan(1'b0, 8, 32'hb5, 99, dout);
			check(32'(dout[7:1]), 32'h35);
			if (codes[k] == bst_pkg::IR_HIGHZ)
				check(32'(padOutEn), 32'h0);
			else if (codes[k] == bst_pkg::IR_CLAMP)
				check(32'({padOut, padOutEn}), 32'hc3ff);
			else
				check(32'({padOut, padOutEn}), 32'({sysOut, sysOutEn}));
		end
		$display("test bypass_codes done");
	endtask

	task automatic test_tms_reset();
		logic [31:0] dout;
		load_ir(bst_pkg::IR_CLAMP);
		tk(1'b1);
		tk(1'b0);
		tk(1'b0);
		bst_tester_inst.tms_reset();
		check(32'({padOut, padOutEn}), 32'({sysOut, sysOutEn}));
		tk(1'b1);
		scan(1'b0, 32, 32'h0, 99, dout);
		check(dout, ID_EXP);
		$display("test tms_reset done");
	endtask

	task automatic test_reset_mid_shift();
		logic [31:0] dout;
		load_ir(bst_pkg::IR_EXTEST);
		tk(1'b1);
		tk(1'b1);
		tk(1'b0);
		tk(1'b0);
		bst_tester_inst.reset_pulse();
		check(32'({padOut, padOutEn}), 32'({sysOut, sysOutEn}));
		scan(1'b0, 32, 32'h0, 99, dout);
		check(dout, ID_EXP);
		$display("test reset_mid_shift done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		mismatches     = 0;
		samplesChecked = 0;
		cycles         = 0;
		rst_n          = 1'b0;
		sysOut         = 8'ha3;
		sysOutEn       = 8'hf0;
		padIn          = 8'h00;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		settle();
		test_reset_id();
		test_sample_extest();
		test_bypass_codes();
		test_tms_reset();
		test_reset_mid_shift();
		end_of_test();
	end

endmodule // testbench
